// ==== bam_pkg.sv ====
// Constants for the per-hart address-match breakpoint unit.
// Assumes CSR numbers and access-kind bit order are shared with the hart pipeline.
package bam_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned BAM_NTRIG = 2;
    localparam int unsigned BAM_MASKMAX = 31;

    // ------------------------------------------------------------
    // CSR numbers of the select register and the three data words
    // ------------------------------------------------------------
    localparam logic [11:0] BAM_CSR_SELECT = 12'h7a0;
    localparam logic [11:0] BAM_CSR_WORD1 = 12'h7a1;
    localparam logic [11:0] BAM_CSR_WORD2 = 12'h7a2;
    localparam logic [11:0] BAM_CSR_WORD3 = 12'h7a3;

    // ------------------------------------------------------------
    // Field positions of the control word
    // ------------------------------------------------------------
    localparam int unsigned BAM_F_LOAD = 0;
    localparam int unsigned BAM_F_STORE = 1;
    localparam int unsigned BAM_F_FETCH = 2;
    localparam int unsigned BAM_F_USER = 3;
    localparam int unsigned BAM_F_SUPV = 4;
    localparam int unsigned BAM_F_MACH = 6;
    localparam int unsigned BAM_F_MATCH = 7;
    localparam int unsigned BAM_F_CHAIN = 11;
    localparam int unsigned BAM_F_ACTION = 12;
    localparam int unsigned BAM_F_MASKMAX = 21;
    localparam int unsigned BAM_F_DMODE = 27;
    localparam int unsigned BAM_F_KIND = 28;

    // ------------------------------------------------------------
    // Field values and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] BAM_KIND_ADDR = 4'h2;
    localparam logic [5:0] BAM_ACT_EXC = 6'h00;
    localparam logic [5:0] BAM_ACT_DBG = 6'h01;
    localparam logic [3:0] BAM_MATCH_EQ = 4'h0;
    localparam logic [3:0] BAM_MATCH_NAPOT = 4'h1;
    localparam logic [3:0] BAM_MATCH_GE = 4'h2;
    localparam logic [3:0] BAM_MATCH_LT = 4'h3;
    localparam logic [31:0] BAM_RST_ADDR = 32'h0000_0000;
    localparam logic [31:0] BAM_CAUSE_BKPT = 32'h0000_0003;

    // ------------------------------------------------------------
    // Privilege codes and access-kind bits from the pipeline
    // ------------------------------------------------------------
    localparam logic [1:0] BAM_PRIV_U = 2'h0;
    localparam logic [1:0] BAM_PRIV_S = 2'h1;
    localparam logic [1:0] BAM_PRIV_M = 2'h3;
    localparam int unsigned BAM_ACC_LOAD = 0;
    localparam int unsigned BAM_ACC_STORE = 1;
    localparam int unsigned BAM_ACC_FETCH = 2;
endpackage : bam_pkg

// ==== bam_breakpoint_match.sv ====
// Per-hart hardware breakpoint unit: CSR-indexed triggers, address compare, trap request.
// Assumes the hart holds a checked access until the registered answer one cycle later.
// Operation
// RULE1: action 0 exception, 1 debug entry only
// RULE2: load/store/fetch bits qualify access kind
// RULE3: M/S/U bits qualify current privilege
// RULE4: 4-bit legalised match kind field
// RULE5: trailing ones then zero give range
// RULE6: 6-bit read-only maskmax field
// RULE7: largest range compares only bit 31
// RULE8: chained pair bounds arbitrary range
// RULE9: code 2 ge, 3 lt, chain gates
// RULE10: compare address full-width read/write
// RULE11: trap raised before access completes
// RULE12: hardware misaligned: any byte in range
// RULE13: emulated halves each checked separately
// RULE14: debug trap leaves machine registers alone
// RULE15: machine trap writes cause and address
// RULE16: debug-owned trigger reads kind 0
// RULE17: kind field reads 2
// RULE18: machine access to debug trigger illegal
// RULE19: two breakpoints per hart
// RULE20: select index picks trigger for data CSRs
// RULE21: address, kind, privilege checked together
`timescale 1ns/1ps
module bam_breakpoint_match #(
    parameter int unsigned NTRIG = bam_pkg::BAM_NTRIG,
    parameter int unsigned MASKMAX = bam_pkg::BAM_MASKMAX,
    parameter bit MISALIGN_HW = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // CSR access port
    input wire logic csr_req,
    input wire logic csr_we,
    input wire logic [11:0] csr_addr,
    input wire logic [31:0] csr_wdata,
    input wire logic csr_dbg,
    output logic csr_ack,
    output logic [31:0] csr_rdata,
    output logic csr_illegal,
    // Access under check from the pipeline
    input wire logic acc_valid,
    input wire logic [2:0] acc_kind,
    input wire logic [31:0] acc_addr,
    input wire logic [1:0] acc_size,
    input wire logic [1:0] acc_priv,
    input wire logic hart_dbg,
    // Trap request
    output logic bp_exc,
    output logic bp_dbg,
    output logic [((NTRIG > 1) ? $clog2(NTRIG) : 1)-1:0] bp_which,
    output logic cause_we,
    output logic [31:0] cause,
    output logic [31:0] badaddr
);
    import bam_pkg::*;

    localparam int unsigned TW = (NTRIG > 1) ? $clog2(NTRIG) : 1;
    // Range mask never reaches bit 31, which always takes part
    localparam logic [31:0] NAPOT_LIM = 32'((64'h1 << MASKMAX) - 64'h1);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_s2_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Trigger state
    // ------------------------------------------------------------
    logic [TW-1:0] sel_r;
    logic [NTRIG-1:0] ld_r, st_r, fe_r, pu_r, ps_r, pm_r;
    logic [NTRIG-1:0] chain_r, act_r, dmode_r;
    logic [3:0] match_r [NTRIG];
    logic [31:0] addr_r [NTRIG];

    // ------------------------------------------------------------
    // CSR decode
    // ------------------------------------------------------------
    logic is_sel, is_w1, is_w2, is_w3, is_data, lock, wr_ok;

    assign is_sel = csr_addr == BAM_CSR_SELECT;
    assign is_w1 = csr_addr == BAM_CSR_WORD1;
    assign is_w2 = csr_addr == BAM_CSR_WORD2;
    assign is_w3 = csr_addr == BAM_CSR_WORD3;
    assign is_data = is_w1 | is_w2 | is_w3;
    // Machine mode loses sight of a debug-owned trigger
    assign lock = dmode_r[sel_r] & ~csr_dbg; // RULE18
    assign wr_ok = csr_req & csr_we & ~lock;

    // Index holds only implemented triggers
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            sel_r <= '0;
        end else if (csr_req && csr_we && is_sel && csr_wdata < 32'(NTRIG)) begin
            sel_r <= csr_wdata[TW-1:0]; // RULE20
        end
    end

    // ------------------------------------------------------------
    // Per-trigger registers and compare
    // ------------------------------------------------------------
    logic [NTRIG-1:0] raw, fire;
    logic [31:0] acc_hi;

    // Highest byte touched, so a straddling access still hits
    assign acc_hi = MISALIGN_HW ? acc_addr + ((32'h1 << acc_size) - 32'h1) : acc_addr; // RULE12

    genvar gi;
    generate
        // One register set and comparator per trigger
        for (gi = 0; gi < NTRIG; gi++) begin : g_trig // RULE19
            logic wsel, dm_new, kind_ok, priv_ok, cmp;
            logic [3:0] mt;
            logic [31:0] mask, base, top;

            assign wsel = wr_ok && sel_r == TW'(gi);
            assign dm_new = csr_dbg ? csr_wdata[BAM_F_DMODE] : dmode_r[gi];
            assign mt = csr_wdata[BAM_F_MATCH +: 4];

            always_ff @(posedge mclk or negedge rst_s2_r) begin
                if (!rst_s2_r) begin
                    {ld_r[gi], st_r[gi], fe_r[gi]} <= 3'h0;
                    {pu_r[gi], ps_r[gi], pm_r[gi]} <= 3'h0;
                    chain_r[gi] <= 1'b0;
                    act_r[gi] <= 1'b0;
                    dmode_r[gi] <= 1'b0;
                    match_r[gi] <= BAM_MATCH_EQ;
                end else if (wsel && is_w1) begin
                    ld_r[gi] <= csr_wdata[BAM_F_LOAD]; // RULE2
                    st_r[gi] <= csr_wdata[BAM_F_STORE];
                    fe_r[gi] <= csr_wdata[BAM_F_FETCH];
                    pu_r[gi] <= csr_wdata[BAM_F_USER]; // RULE3
                    ps_r[gi] <= csr_wdata[BAM_F_SUPV];
                    pm_r[gi] <= csr_wdata[BAM_F_MACH];
                    // Unsupported kinds fall back to exact match
                    if (mt > BAM_MATCH_LT || (mt == BAM_MATCH_NAPOT && MASKMAX == 0)) begin
                        match_r[gi] <= BAM_MATCH_EQ; // RULE4
                    end else begin
                        match_r[gi] <= mt;
                    end
                    chain_r[gi] <= (gi < NTRIG - 1) ? csr_wdata[BAM_F_CHAIN] : 1'b0;
                    // Debug entry is only legal on a debug-owned trigger
                    act_r[gi] <= csr_wdata[BAM_F_ACTION +: 6] == BAM_ACT_DBG && dm_new; // RULE1
                    dmode_r[gi] <= dm_new;
                end
            end

            always_ff @(posedge mclk or negedge rst_s2_r) begin
                if (!rst_s2_r) begin
                    addr_r[gi] <= BAM_RST_ADDR;
                end else if (wsel && is_w2) begin
                    addr_r[gi] <= csr_wdata; // RULE10
                end
            end

            // Trailing ones plus the first zero are the size code, not address
            assign mask = (addr_r[gi] ^ (addr_r[gi] + 32'h1)) & NAPOT_LIM; // RULE5 RULE7
            assign base = addr_r[gi] & ~mask;
            assign top = base | mask;

            always_comb begin
                unique case (match_r[gi])
                    BAM_MATCH_EQ: cmp = acc_hi >= addr_r[gi] && acc_addr <= addr_r[gi];
                    BAM_MATCH_NAPOT: cmp = acc_hi >= base && acc_addr <= top; // RULE5
                    BAM_MATCH_GE: cmp = acc_hi >= addr_r[gi]; // RULE9
                    BAM_MATCH_LT: cmp = acc_addr < addr_r[gi]; // RULE9
                    default: cmp = 1'b0;
                endcase
            end

            assign kind_ok = (acc_kind[BAM_ACC_LOAD] & ld_r[gi]) | (acc_kind[BAM_ACC_STORE] & st_r[gi])
                | (acc_kind[BAM_ACC_FETCH] & fe_r[gi]); // RULE2

            always_comb begin
                unique case (acc_priv)
                    BAM_PRIV_U: priv_ok = pu_r[gi]; // RULE3
                    BAM_PRIV_S: priv_ok = ps_r[gi];
                    BAM_PRIV_M: priv_ok = pm_r[gi];
                    default: priv_ok = 1'b0;
                endcase
            end

            // Each emulated half arrives as its own access and is checked alone
            assign raw[gi] = acc_valid & ~hart_dbg & cmp & kind_ok & priv_ok; // RULE21 RULE13

            // A chained trigger defers to its neighbour, which needs both to match
            if (gi == 0) begin : g_first
                assign fire[gi] = raw[gi] & ~chain_r[gi];
            end else begin : g_next
                assign fire[gi] = raw[gi] & ~chain_r[gi] & (~chain_r[gi-1] | raw[gi-1]); // RULE8 RULE9
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // CSR read and answer
    // ------------------------------------------------------------
    logic [31:0] rd_nxt;
    logic [31:0] ctl_word;

    // Control word of the selected trigger; timing and select read 0
    always_comb begin
        ctl_word = '0;
        ctl_word[BAM_F_LOAD] = ld_r[sel_r];
        ctl_word[BAM_F_STORE] = st_r[sel_r];
        ctl_word[BAM_F_FETCH] = fe_r[sel_r];
        ctl_word[BAM_F_USER] = pu_r[sel_r];
        ctl_word[BAM_F_SUPV] = ps_r[sel_r];
        ctl_word[BAM_F_MACH] = pm_r[sel_r];
        ctl_word[BAM_F_MATCH +: 4] = match_r[sel_r];
        ctl_word[BAM_F_CHAIN] = chain_r[sel_r];
        ctl_word[BAM_F_ACTION +: 6] = act_r[sel_r] ? BAM_ACT_DBG : BAM_ACT_EXC;
        ctl_word[BAM_F_MASKMAX +: 6] = 6'(MASKMAX); // RULE6
        ctl_word[BAM_F_DMODE] = dmode_r[sel_r];
        ctl_word[BAM_F_KIND +: 4] = BAM_KIND_ADDR; // RULE17
    end

    // Locked and reserved words read as zero
    always_comb begin
        rd_nxt = '0;
        if (is_sel) begin
            rd_nxt = 32'(sel_r);
        end else if (is_w1 && !lock) begin
            rd_nxt = ctl_word; // RULE16
        end else if (is_w2 && !lock) begin
            rd_nxt = addr_r[sel_r];
        end
    end

    // Answer, data and refusal all stand for one cycle
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            csr_ack <= 1'b0;
            csr_rdata <= '0;
            csr_illegal <= 1'b0;
        end else begin
            csr_ack <= csr_req & (is_sel | is_data);
            csr_rdata <= csr_req ? rd_nxt : '0;
            csr_illegal <= csr_req & is_data & lock; // RULE18
        end
    end

    // ------------------------------------------------------------
    // Trap request
    // ------------------------------------------------------------
    logic any_dbg, any_exc;
    logic [TW-1:0] which_nxt;

    // Debug entry outranks an exception raised in the same cycle
    assign any_dbg = |(fire & act_r);
    assign any_exc = |(fire & ~act_r) & ~any_dbg;

    // Lowest trigger of the winning action is reported
    always_comb begin
        which_nxt = '0;
        for (int i = NTRIG - 1; i >= 0; i--) begin
            if (fire[i] && (act_r[i] || !any_dbg)) begin
                which_nxt = TW'(i);
            end
        end
    end

    // Trap pulses answer the access taken at the previous edge
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            bp_exc <= 1'b0;
            bp_dbg <= 1'b0;
            bp_which <= '0;
        end else begin
            bp_dbg <= any_dbg; // RULE1 RULE11
            bp_exc <= any_exc; // RULE1 RULE11
            bp_which <= which_nxt;
        end
    end

    // Debug entry never touches the machine trap registers
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            cause_we <= 1'b0;
            cause <= '0;
            badaddr <= '0;
        end else begin
            cause_we <= any_exc; // RULE14 RULE15
            if (any_exc) begin
                cause <= BAM_CAUSE_BKPT; // RULE15
                badaddr <= acc_addr;
            end
        end
    end
endmodule : bam_breakpoint_match

// ==== bam_breakpoint_match_asserts.sv ====
// Checker for the breakpoint unit, fed from the top-level ports.
// Assumes a bind into bam_breakpoint_match from the bench top file.
`timescale 1ns/1ps
module bam_breakpoint_match_asserts import bam_pkg::*; #(
    parameter int unsigned MASKMAX = BAM_MASKMAX
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // CSR port
    input wire logic csr_req,
    input wire logic csr_we,
    input wire logic [11:0] csr_addr,
    input wire logic csr_ack,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_illegal,
    // Access and trap
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic hart_dbg,
    input wire logic bp_exc,
    input wire logic bp_dbg,
    input wire logic cause_we,
    input wire logic [31:0] cause,
    input wire logic [31:0] badaddr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_take; csr_req && csr_addr[11:2] == BAM_CSR_SELECT[11:2]; endsequence
    sequence s_rd_ctrl; csr_req && !csr_we && csr_addr == BAM_CSR_WORD1 ##1 csr_ack && !csr_illegal; endsequence
    property p_ack; s_take |=> csr_ack; endproperty
    a_ack: assert property (p_ack) else $error("CSR access not acknowledged");
    property p_kind; s_rd_ctrl |-> csr_rdata[31:28] == BAM_KIND_ADDR; endproperty
    a_kind: assert property (p_kind) else $error("kind field wrong");
    property p_maskmax; s_rd_ctrl |-> csr_rdata[26:21] == 6'(MASKMAX); endproperty
    a_maskmax: assert property (p_maskmax) else $error("maskmax field wrong");
    property p_illegal; csr_illegal |-> csr_ack && csr_rdata == 32'h0; endproperty
    a_illegal: assert property (p_illegal) else $error("refused access leaked data");
    property p_one_act; cause_we == bp_exc && !(bp_exc && bp_dbg); endproperty
    a_one_act: assert property (p_one_act) else $error("two actions at once");
    property p_cause; bp_exc |-> cause == BAM_CAUSE_BKPT && badaddr == $past(acc_addr); endproperty
    a_cause: assert property (p_cause) else $error("trap cause or address wrong");
    property p_dbg_quiet; bp_dbg |-> $stable(cause) && $stable(badaddr); endproperty
    a_dbg_quiet: assert property (p_dbg_quiet) else $error("debug hit changed trap regs");
    property p_no_acc; (!acc_valid || hart_dbg) |=> !bp_exc && !bp_dbg; endproperty
    a_no_acc: assert property (p_no_acc) else $error("hit without access");
endmodule : bam_breakpoint_match_asserts

// ==== bam_hart_model.sv ====
// Hart pipeline stand-in: presents one access and waits for the trap answer.
// Assumes the unit answers exactly one cycle after taking an access.
`timescale 1ns/1ps
module bam_hart_model (
    // Clock
    input wire logic mclk,
    // Access under check
    output logic acc_valid,
    output logic [2:0] acc_kind,
    output logic [31:0] acc_addr,
    output logic [1:0] acc_size,
    output logic [1:0] acc_priv,
    output logic hart_dbg,
    // Trap request
    input wire logic bp_exc,
    input wire logic bp_dbg
);
    initial begin
        acc_valid = 1'b0;
        acc_kind = 3'h0;
        acc_addr = 32'h0;
        acc_size = 2'h0;
        acc_priv = 2'h0;
        hart_dbg = 1'b0;
    end
    task automatic issue(input logic [2:0] k, input logic [31:0] a, input logic [1:0] s, input logic [1:0] p,
                         input logic hd, output logic ge, output logic gd);
        @(posedge mclk);
        #2;
        acc_valid = 1'b1;
        acc_kind = k;
        acc_addr = a;
        acc_size = s;
        acc_priv = p;
        hart_dbg = hd;
        @(posedge mclk);
        #2;
        // Access is only committed once the answer cycle has been seen
        ge = bp_exc;
        gd = bp_dbg;
        acc_valid = 1'b0;
        acc_addr = ~a;
        hart_dbg = 1'b0;
    endtask : issue
endmodule : bam_hart_model

// ==== test_bam_breakpoint_match.sv ====
// Self-checking bench: CSR read/write tasks and a sequence of accesses.
// Assumes bam_hart_model presents accesses; the checker is bound below.
`timescale 1ns/1ps
module test_bam_breakpoint_match;
    import bam_pkg::*;
    localparam logic [11:0] SEL = BAM_CSR_SELECT;
    localparam logic [11:0] CW = BAM_CSR_WORD1;
    localparam logic [11:0] AW = BAM_CSR_WORD2;
    localparam logic [31:0] CRST = {BAM_KIND_ADDR, 1'b0, 6'(BAM_MASKMAX), 21'h0};
    localparam logic [2:0] LD = 3'b001;
    localparam logic [2:0] ST = 3'b010;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic csr_req = 1'b0;
    logic csr_we = 1'b0;
    logic [11:0] csr_addr = 12'h0;
    logic [31:0] csr_wdata = 32'h0;
    logic csr_dbg = 1'b0;
    logic csr_ack, csr_illegal, acc_valid, hart_dbg, bp_exc, bp_dbg, cause_we, ak, il, ge, gd;
    logic [31:0] csr_rdata, acc_addr, cause, badaddr, rd;
    logic [2:0] acc_kind;
    logic [1:0] acc_size, acc_priv;
    logic [0:0] bp_which;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    bam_breakpoint_match uut (.mclk(mclk), .rstn(rstn), .csr_req(csr_req), .csr_we(csr_we),
        .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_dbg(csr_dbg), .csr_ack(csr_ack),
        .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .acc_valid(acc_valid), .acc_kind(acc_kind),
        .acc_addr(acc_addr), .acc_size(acc_size), .acc_priv(acc_priv), .hart_dbg(hart_dbg),
        .bp_exc(bp_exc), .bp_dbg(bp_dbg), .bp_which(bp_which), .cause_we(cause_we), .cause(cause),
        .badaddr(badaddr));
    bam_hart_model hart (.mclk(mclk), .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr),
        .acc_size(acc_size), .acc_priv(acc_priv), .hart_dbg(hart_dbg), .bp_exc(bp_exc), .bp_dbg(bp_dbg));
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic csr(input logic we, input logic [11:0] a, input logic [31:0] d, input logic dbg);
        @(posedge mclk);
        #2;
        csr_req = 1'b1;
        csr_we = we;
        csr_addr = a;
        csr_wdata = d;
        csr_dbg = dbg;
        @(posedge mclk);
        #2;
        csr_req = 1'b0;
        csr_wdata = ~d;
        ak = csr_ack;
        il = csr_illegal;
        rd = csr_rdata;
    endtask : csr
    task automatic rdchk(input logic [11:0] a, input logic dbg, input logic ea, ei, input logic [31:0] e);
        csr(1'b0, a, 32'h0, dbg);
        check({ak, il, rd}, {ea, ei, e});
    endtask : rdchk
    task automatic acc(input logic [2:0] k, input logic [31:0] a, input logic [1:0] s, p, input logic hd, ee, ed);
        hart.issue(k, a, s, p, hd, ge, gd);
        check({ge, gd, cause_we}, {ee, ed, ee});
        if (ee) check({cause, badaddr}, {BAM_CAUSE_BKPT, a});
    endtask : acc
    task automatic conclude();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (6) @(posedge mclk);
        #2;
        rstn = 1'b1;
        repeat (2) @(posedge mclk);
        rdchk(CW, 1'b0, 1'b1, 1'b0, CRST);
        csr(1'b1, SEL, 32'h5, 1'b0);
        rdchk(SEL, 1'b0, 1'b1, 1'b0, 32'h0);
        csr(1'b1, SEL, 32'h1, 1'b0);
        rdchk(SEL, 1'b0, 1'b1, 1'b0, 32'h1);
        csr(1'b1, AW, 32'h1234_5679, 1'b0);
        rdchk(AW, 1'b0, 1'b1, 1'b0, 32'h1234_5679);
        rdchk(BAM_CSR_WORD3, 1'b0, 1'b1, 1'b0, 32'h0);
        rdchk(12'h7a4, 1'b0, 1'b0, 1'b0, 32'h0);
        csr(1'b1, CW, 32'h0003_f380, 1'b0);
        rdchk(CW, 1'b0, 1'b1, 1'b0, CRST);
        csr(1'b1, SEL, 32'h0, 1'b0);
        csr(1'b1, CW, 32'h0000_0041, 1'b0);
        csr(1'b1, AW, 32'h1000_0000, 1'b0);
        acc(LD, 32'h1000_0000, 2'h0, BAM_PRIV_M, 1'b0, 1'b1, 1'b0);
        check(bp_which, 1'b0);
        acc(ST, 32'h1000_0000, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        acc(LD, 32'h1000_0000, 2'h0, BAM_PRIV_U, 1'b0, 1'b0, 1'b0);
        acc(LD, 32'h0fff_ffff, 2'h1, BAM_PRIV_M, 1'b0, 1'b1, 1'b0);
        acc(LD, 32'h0fff_ffff, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        acc(LD, 32'h1000_0000, 2'h0, BAM_PRIV_M, 1'b1, 1'b0, 1'b0);
        acc(LD, 32'h1000_0001, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        csr(1'b1, CW, 32'h0000_00d1, 1'b0);
        csr(1'b1, AW, 32'h2000_0007, 1'b0);
        acc(LD, 32'h2000_000f, 2'h0, BAM_PRIV_S, 1'b0, 1'b1, 1'b0);
        acc(LD, 32'h2000_0010, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        acc(LD, 32'h2000_0000, 2'h0, BAM_PRIV_U, 1'b0, 1'b0, 1'b0);
        csr(1'b1, AW, 32'h3fff_ffff, 1'b0);
        acc(LD, 32'h7fff_fff0, 2'h2, BAM_PRIV_M, 1'b0, 1'b1, 1'b0);
        acc(LD, 32'h8000_0000, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        csr(1'b1, CW, 32'h0800_0941, 1'b1);
        csr(1'b1, AW, 32'h4000_0000, 1'b1);
        csr(1'b1, SEL, 32'h1, 1'b1);
        csr(1'b1, CW, 32'h0800_11c1, 1'b1);
        csr(1'b1, AW, 32'h4000_0100, 1'b1);
        acc(LD, 32'h4000_0010, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b1);
        check(badaddr, 32'h7fff_fff0);
        check(bp_which, 1'b1);
        acc(LD, 32'h4000_0100, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        acc(LD, 32'h3fff_fff0, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        acc(LD, 32'h5000_0000, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b0);
        rdchk(CW, 1'b0, 1'b1, 1'b1, 32'h0);
        rdchk(CW, 1'b1, 1'b1, 1'b0, 32'h2be0_11c1);
        csr(1'b1, AW, 32'h0, 1'b0);
        rdchk(AW, 1'b1, 1'b1, 1'b0, 32'h4000_0100);
        csr(1'b1, SEL, 32'h0, 1'b1);
        csr(1'b1, CW, 32'h0000_004f, 1'b1);
        rdchk(CW, 1'b0, 1'b1, 1'b0, 32'h23e0_004f);
        acc(ST, 32'h4000_0000, 2'h0, BAM_PRIV_M, 1'b0, 1'b1, 1'b0);
        acc(3'b100, 32'h3fff_fffe, 2'h2, BAM_PRIV_U, 1'b0, 1'b1, 1'b0);
        acc(ST, 32'h4000_0000, 2'h0, BAM_PRIV_S, 1'b0, 1'b0, 1'b0);
        acc(LD, 32'h4000_0000, 2'h0, BAM_PRIV_M, 1'b0, 1'b0, 1'b1);
        check({bp_which, badaddr}, {1'b1, 32'h3fff_fffe});
        rstn = 1'b0;
        repeat (2) @(posedge mclk);
        #2;
        rstn = 1'b1;
        repeat (2) @(posedge mclk);
        rdchk(CW, 1'b0, 1'b1, 1'b0, CRST);
        check({cause, badaddr}, 64'h0);
        rdchk(AW, 1'b0, 1'b1, 1'b0, 32'h0);
        conclude();
    end
endmodule : test_bam_breakpoint_match
bind bam_breakpoint_match bam_breakpoint_match_asserts #(.MASKMAX(MASKMAX)) chk (.mclk(mclk), .rstn(rstn),
    .csr_req(csr_req), .csr_we(csr_we), .csr_addr(csr_addr), .csr_ack(csr_ack), .csr_rdata(csr_rdata),
    .csr_illegal(csr_illegal), .acc_valid(acc_valid), .acc_addr(acc_addr), .hart_dbg(hart_dbg),
    .bp_exc(bp_exc), .bp_dbg(bp_dbg), .cause_we(cause_we), .cause(cause), .badaddr(badaddr));
